// file: seq_defs.svh
// Offsets, field positions, reset values and timing counts of the step sequencer
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

`define SEQ_ADDR_END_MODE   8'h00
`define SEQ_ADDR_RETAIN     8'h01
`define SEQ_ADDR_TIME_UNIT  8'h02
`define SEQ_ADDR_OUT_SEL    8'h03
`define SEQ_ADDR_STATUS     8'h04
`define SEQ_ADDR_ELAPSED    8'h05
`define SEQ_GRP_RUN_TIME    4'h1
`define SEQ_GRP_RAMP        4'h2
`define SEQ_GRP_REF         4'h3

`define SEQ_RET_UNITS_MSB   3
`define SEQ_RET_UNITS_LSB   0
`define SEQ_RET_TENS_MSB    7
`define SEQ_RET_TENS_LSB    4
`define SEQ_DIGIT_ON        4'h1

`define SEQ_MODE_STOP       2'h0
`define SEQ_MODE_KEEP       2'h1
`define SEQ_MODE_REPEAT     2'h2
`define SEQ_LAST_STEP       4'hF

`define SEQ_END_MODE_RST    2'h0
`define SEQ_RETAIN_RST      8'h00
`define SEQ_TIME_UNIT_RST   1'h0
`define SEQ_OUT_SEL_RST     1'h0
`define SEQ_RUN_TIME_RST    16'h0000
`define SEQ_RAMP_RST        2'h0
`define SEQ_REF_RST         16'h0000

`define SEQ_CLK_PERIOD_NS   10
`define SEQ_TENTH_SEC_NS    100000000
`define SEQ_TENTH_CYCLES    (`SEQ_TENTH_SEC_NS / `SEQ_CLK_PERIOD_NS)
`define SEQ_SEC_PER_HOUR    3600

`endif

// file: seq_pkg.sv
// Types shared by the step sequencer modules
package seq_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SEEK,
    SEQ_RUN,
    SEQ_HOLD
  } seq_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } seq_bus_req_t;

  typedef struct packed {
    logic runCmd;
    logic stopCmd;
    logic powerLoss;
    logic powerReturn;
  } seq_ctrl_t;

  typedef struct packed {
    logic        run;
    logic        reverse;
    logic [15:0] freqRef;
    logic [15:0] voltRef;
    logic [1:0]  rampSel;
  } seq_drive_t;

endpackage

// file: seq_sequencer.sv
// Multi-step speed sequencer with register port
//
// Overview of operation
// - Mode 0: stop after one cycle
// - Mode 1: keep last step's output
// - Mode 2: repeat cycles until stop
// - Reference sign sets rotation direction on the frequency output only
// - Units digit: resume after power loss
// - Tens digit: resume after stop
// - Reset: retention 00, end mode 0
// - Per-step running time, tenths, default zero
// - Per-step two-bit ramp set select
// - Output drives frequency or voltage reference
// - Time unit: seconds or hours
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "seq_defs.svh"
module seq_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = `SEQ_TENTH_CYCLES,
  parameter int unsigned HOUR_SCALE   = `SEQ_SEC_PER_HOUR
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire seq_bus_req_t busReq,
  output logic [15:0]       rdata,
  input  wire seq_ctrl_t    ctrl,
  output seq_drive_t        drive
);

  logic [1:0]  endMode_q;
  logic [7:0]  retain_q;
  logic        timeUnit_q;
  logic        outSel_q;
  logic [15:0] runTime_q [16];
  logic [1:0]  rampSel_q [16];
  logic [15:0] stepRef_q [16];

  seq_state_t  state_q;
  logic [3:0]  step_q;
  logic [15:0] elapsed_q;
  logic        ranCycle_q;
  logic        stopValid_q;
  logic [3:0]  stopStep_q;
  logic [15:0] stopElapsed_q;
  logic        pfActive_q;
  logic [3:0]  pfStep_q;
  logic [15:0] pfElapsed_q;

  logic        tick;
  logic        active;
  logic        unitsOn;
  logic        tensOn;
  logic        stepDone;
  logic        seekSkip;
  logic        advance;
  logic        wrapEnd;
  logic        anyRan;
  logic        quiet;
  logic [15:0] curRef;
  logic [15:0] curTime;

  function automatic logic [15:0] absVal(input logic [15:0] v);
    absVal = v[15] ? (16'h0000 - v) : v;
  endfunction

  function automatic logic digitOn(input logic [3:0] d);
    digitOn = (d == `SEQ_DIGIT_ON);
  endfunction

  assign active  = (state_q == SEQ_SEEK) || (state_q == SEQ_RUN);
  assign unitsOn = digitOn(retain_q[`SEQ_RET_UNITS_MSB:`SEQ_RET_UNITS_LSB]);
  assign tensOn  = digitOn(retain_q[`SEQ_RET_TENS_MSB:`SEQ_RET_TENS_LSB]);
  assign curRef  = stepRef_q[step_q];
  assign curTime = runTime_q[step_q];
  assign quiet   = !ctrl.stopCmd && !ctrl.powerLoss;
  // Greater-or-equal so a time shortened mid-step still ends it
  assign stepDone = (state_q == SEQ_RUN) && tick && (({1'b0, elapsed_q} + 17'h00001) >= {1'b0, curTime});
  assign seekSkip = (state_q == SEQ_SEEK) && (curTime == `SEQ_RUN_TIME_RST);
  assign advance  = stepDone || seekSkip;
  assign wrapEnd  = advance && (step_q == `SEQ_LAST_STEP);
  assign anyRan   = ranCycle_q || stepDone;

  seq_tick_gen #(
    .TENTH_CYCLES (TENTH_CYCLES),
    .HOUR_SCALE   (HOUR_SCALE)
  ) u_tick (
    .clk      (clk),
    .nrst     (nrst),
    .enable   (state_q == SEQ_RUN),
    .hourUnit (timeUnit_q),
    .tick     (tick)
  );

  // Configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      endMode_q  <= `SEQ_END_MODE_RST;
      retain_q   <= `SEQ_RETAIN_RST;
      timeUnit_q <= `SEQ_TIME_UNIT_RST;
      outSel_q   <= `SEQ_OUT_SEL_RST;
    end else if (busReq.wr) begin
      case (busReq.addr)
        `SEQ_ADDR_END_MODE:  endMode_q  <= busReq.wdata[1:0];
        `SEQ_ADDR_RETAIN:    retain_q   <= busReq.wdata[7:0];
        `SEQ_ADDR_TIME_UNIT: timeUnit_q <= busReq.wdata[0];
        `SEQ_ADDR_OUT_SEL:   outSel_q   <= busReq.wdata[0];
        default: ;
      endcase
    end
  end

  // Step tables
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        runTime_q[i] <= `SEQ_RUN_TIME_RST;
        rampSel_q[i] <= `SEQ_RAMP_RST;
        stepRef_q[i] <= `SEQ_REF_RST;
      end
    end else if (busReq.wr) begin
      case (busReq.addr[7:4])
        `SEQ_GRP_RUN_TIME: runTime_q[busReq.addr[3:0]] <= busReq.wdata;
        `SEQ_GRP_RAMP:     rampSel_q[busReq.addr[3:0]] <= busReq.wdata[1:0];
        `SEQ_GRP_REF:      stepRef_q[busReq.addr[3:0]] <= busReq.wdata;
        default: ;
      endcase
    end
  end

  // Read port, data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (!busReq.rd) begin
      rdata <= 16'h0000;
    end else begin
      case (busReq.addr[7:4])
        `SEQ_GRP_RUN_TIME: rdata <= runTime_q[busReq.addr[3:0]];
        `SEQ_GRP_RAMP:     rdata <= {14'h0000, rampSel_q[busReq.addr[3:0]]};
        `SEQ_GRP_REF:      rdata <= stepRef_q[busReq.addr[3:0]];
        4'h0: begin
          case (busReq.addr)
            `SEQ_ADDR_END_MODE:  rdata <= {14'h0000, endMode_q};
            `SEQ_ADDR_RETAIN:    rdata <= {8'h00, retain_q};
            `SEQ_ADDR_TIME_UNIT: rdata <= {15'h0000, timeUnit_q};
            `SEQ_ADDR_OUT_SEL:   rdata <= {15'h0000, outSel_q};
            `SEQ_ADDR_STATUS:    rdata <= {8'h00, stopValid_q, pfActive_q, state_q, step_q};
            `SEQ_ADDR_ELAPSED:   rdata <= elapsed_q;
            default:             rdata <= 16'h0000;
          endcase
        end
        default: rdata <= 16'h0000;
      endcase
    end
  end

  // Sequence state: power loss beats stop, stop beats everything else
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= SEQ_IDLE;
      step_q     <= 4'h0;
      elapsed_q  <= 16'h0000;
      ranCycle_q <= 1'b0;
    end else if (ctrl.powerLoss) begin
      state_q <= SEQ_IDLE;
    end else if (ctrl.stopCmd) begin
      state_q <= SEQ_IDLE;
    end else begin
      case (state_q)
        SEQ_IDLE: begin
          if (ctrl.powerReturn && pfActive_q) begin
            state_q    <= SEQ_SEEK;
            ranCycle_q <= 1'b0;
            if (unitsOn) begin
              step_q    <= pfStep_q;
              elapsed_q <= pfElapsed_q;
            end else begin
              step_q    <= 4'h0;
              elapsed_q <= 16'h0000;
            end
          end else if (ctrl.runCmd) begin
            state_q    <= SEQ_SEEK;
            ranCycle_q <= 1'b0;
            if (tensOn && stopValid_q) begin
              step_q    <= stopStep_q;
              elapsed_q <= stopElapsed_q;
            end else begin
              step_q    <= 4'h0;
              elapsed_q <= 16'h0000;
            end
          end
        end
        SEQ_SEEK, SEQ_RUN: begin
          if (state_q == SEQ_SEEK && !seekSkip) begin
            state_q    <= SEQ_RUN;
            ranCycle_q <= 1'b1;
          end else if (wrapEnd) begin
            elapsed_q <= 16'h0000;
            // A cycle with no programmed step ends rather than spinning
            if (endMode_q == `SEQ_MODE_KEEP && anyRan) begin
              state_q <= SEQ_HOLD;
            end else if (endMode_q == `SEQ_MODE_REPEAT && anyRan) begin
              state_q    <= SEQ_SEEK;
              step_q     <= 4'h0;
              ranCycle_q <= 1'b0;
            end else begin
              state_q <= SEQ_IDLE;
            end
          end else if (advance) begin
            state_q   <= SEQ_SEEK;
            step_q    <= step_q + 4'h1;
            elapsed_q <= 16'h0000;
          end else if (tick) begin
            elapsed_q <= elapsed_q + 16'h0001;
          end
        end
        SEQ_HOLD: state_q <= SEQ_HOLD;
        default:  state_q <= SEQ_IDLE;
      endcase
    end
  end

  // Retention snapshots
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stopValid_q   <= 1'b0;
      stopStep_q    <= 4'h0;
      stopElapsed_q <= 16'h0000;
      pfActive_q    <= 1'b0;
      pfStep_q      <= 4'h0;
      pfElapsed_q   <= 16'h0000;
    end else if (ctrl.powerLoss) begin
      pfActive_q  <= active || pfActive_q;
      pfStep_q    <= active ? step_q : pfStep_q;
      pfElapsed_q <= active ? elapsed_q : pfElapsed_q;
    end else if (ctrl.stopCmd) begin
      pfActive_q    <= 1'b0;
      // A second stop while idle must not lose the point
      if (active) begin
        stopValid_q   <= tensOn;
        stopStep_q    <= step_q;
        stopElapsed_q <= elapsed_q;
      end
    end else if (state_q == SEQ_IDLE && (ctrl.runCmd || ctrl.powerReturn)) begin
      stopValid_q <= 1'b0;
      pfActive_q  <= 1'b0;
    end
  end

  // Drive outputs; the sign only steers direction on the frequency path
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive <= '0;
    end else if (!quiet || state_q == SEQ_IDLE) begin
      drive <= '0;
    end else if (state_q == SEQ_RUN) begin
      drive.run     <= 1'b1;
      drive.rampSel <= rampSel_q[step_q];
      if (outSel_q == 1'b0) begin
        drive.freqRef <= absVal(curRef);
        drive.reverse <= curRef[15];
        drive.voltRef <= 16'h0000;
      end else begin
        drive.voltRef <= absVal(curRef);
        drive.freqRef <= 16'h0000;
        drive.reverse <= 1'b0;
      end
    end else begin
      drive.run <= 1'b1;
    end
  end

  stop_cycle_a: assert property (@(posedge clk) disable iff (!nrst)
    wrapEnd && quiet && endMode_q == `SEQ_MODE_STOP |=> state_q == SEQ_IDLE ##1 !drive.run)
    else $error("mode 0 did not stop after the cycle");

  hold_final_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == SEQ_HOLD && $past(state_q) == SEQ_HOLD && quiet
      |=> $stable(drive.freqRef) && $stable(drive.reverse) && drive.run)
    else $error("held output changed in mode 1");

  repeat_cycle_a: assert property (@(posedge clk) disable iff (!nrst)
    wrapEnd && anyRan && quiet && endMode_q == `SEQ_MODE_REPEAT
      |=> state_q == SEQ_SEEK && step_q == 4'h0)
    else $error("mode 2 did not restart at the first step");

  sign_direction_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == SEQ_RUN && quiet && !outSel_q |=> drive.reverse == $past(curRef[15]))
    else $error("direction does not follow reference sign");

  power_resume_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == SEQ_IDLE && ctrl.powerReturn && pfActive_q && quiet
      |=> step_q == ($past(unitsOn) ? $past(pfStep_q) : 4'h0) && state_q == SEQ_SEEK)
    else $error("wrong resume point after power return");

  stop_resume_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == SEQ_IDLE && ctrl.runCmd && !ctrl.powerReturn && quiet && tensOn && stopValid_q
      |=> step_q == $past(stopStep_q) && elapsed_q == $past(stopElapsed_q))
    else $error("run did not resume from the stop point");

  ramp_select_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == SEQ_RUN && quiet |=> drive.rampSel == $past(rampSel_q[step_q]))
    else $error("ramp set does not follow the step");

  volt_path_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == SEQ_RUN && quiet && outSel_q |=> drive.freqRef == 16'h0000 && !drive.reverse)
    else $error("voltage mode leaked into frequency reference");

  step_advance_a: assert property (@(posedge clk) disable iff (!nrst)
    advance && !wrapEnd && quiet |=> step_q == $past(step_q) + 4'h1 && elapsed_q == 16'h0000)
    else $error("step did not advance in order");

  zero_skip_a: assert property (@(posedge clk) disable iff (!nrst)
    seekSkip && quiet |=> state_q != SEQ_RUN)
    else $error("zero-time step was run");

  reset_default_a: assert property (@(posedge clk) disable iff (!nrst)
    !$past(nrst) |-> endMode_q == `SEQ_END_MODE_RST && retain_q == `SEQ_RETAIN_RST)
    else $error("settings not at defaults after reset");

  elapsed_count_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == SEQ_RUN && tick && !stepDone && quiet |=> elapsed_q == $past(elapsed_q) + 16'h0001)
    else $error("elapsed time did not count the tick");

  step_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == SEQ_RUN && !tick && quiet |=> $stable(step_q) && state_q == SEQ_RUN)
    else $error("step left before its time ran out");

  stop_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    !quiet |=> !drive.run && state_q == SEQ_IDLE)
    else $error("stop or power loss did not halt the drive");

  stop_record_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.stopCmd && !ctrl.powerLoss && active && tensOn |=> stopValid_q && stopStep_q == $past(step_q))
    else $error("stop point not recorded");

  loss_record_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.powerLoss && active |=> pfActive_q && pfStep_q == $past(step_q))
    else $error("power loss point not recorded");

  time_unit_a: assert property (@(posedge clk) disable iff (!nrst)
    busReq.wr && busReq.addr == `SEQ_ADDR_TIME_UNIT |=> timeUnit_q == $past(busReq.wdata[0]))
    else $error("time unit setting not taken");

endmodule

// file: seq_tick_gen.sv
// Tenth-of-a-unit timebase for step running times
`timescale 1ns/10ps
`include "seq_defs.svh"
module seq_tick_gen
  import seq_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = `SEQ_TENTH_CYCLES,
  parameter int unsigned HOUR_SCALE   = `SEQ_SEC_PER_HOUR
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic hourUnit,
  output logic      tick
);

  logic [23:0] cycleCnt_q;
  logic [11:0] secCnt_q;
  logic        tenthSec;

  assign tenthSec = enable && (cycleCnt_q == 24'(TENTH_CYCLES - 1));

  // Counters restart whenever the state is not SEQ_RUN (idle, seek, hold) so each step gets full tenths
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cycleCnt_q <= 24'h000000;
    end else if (!enable || tenthSec) begin
      cycleCnt_q <= 24'h000000;
    end else begin
      cycleCnt_q <= cycleCnt_q + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      secCnt_q <= 12'h000;
    end else if (!enable || !hourUnit) begin
      secCnt_q <= 12'h000;
    end else if (tenthSec) begin
      secCnt_q <= (secCnt_q == 12'(HOUR_SCALE - 1)) ? 12'h000 : secCnt_q + 12'h001;
    end
  end

  // A tenth of an hour is HOUR_SCALE tenths of a second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick <= 1'b0;
    end else if (hourUnit) begin
      tick <= tenthSec && (secCnt_q == 12'(HOUR_SCALE - 1));
    end else begin
      tick <= tenthSec;
    end
  end

  second_tick_a: assert property (@(posedge clk) disable iff (!nrst)
    !hourUnit && tenthSec |=> tick)
    else $error("seconds unit missed a tenth tick");

  hour_scale_a: assert property (@(posedge clk) disable iff (!nrst)
    hourUnit && tenthSec && secCnt_q != 12'(HOUR_SCALE - 1) |=> !tick)
    else $error("hours unit ticked early");

endmodule

// file: test_seq_sequencer.sv
// Register-level and sequence-level testbench of the step sequencer
`timescale 1ns/10ps
`include "seq_defs.svh"
module test_seq_sequencer
  import seq_pkg::*;
;
  // Short timebase keeps a tenth at 10 cycles and an hour at 3 seconds
  localparam int unsigned TenthCycles = 10;
  localparam int unsigned HourScale   = 3;
  localparam seq_ctrl_t   RunP        = 4'h8;
  localparam seq_ctrl_t   StopP       = 4'h4;
  localparam seq_ctrl_t   LossP       = 4'h2;
  localparam seq_ctrl_t   RetP        = 4'h1;

  logic         clk;
  logic         nrst;
  seq_bus_req_t busReq;
  logic [15:0]  rdata;
  seq_ctrl_t    ctrl;
  seq_drive_t   drive;
  int           errors;
  int           samples_checked;
  int           waited;
  logic [15:0]  got;

  seq_sequencer #(
    .TENTH_CYCLES(TenthCycles),
    .HOUR_SCALE  (HourScale)
  ) dut (
    .clk   (clk),
    .nrst  (nrst),
    .busReq(busReq),
    .rdata (rdata),
    .ctrl  (ctrl),
    .drive (drive)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e, input string what);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq <= '0;
    #1;
    d = rdata;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
    bus_rd(a, got);
    chk_val(got, e, "register");
  endtask

  task automatic pulse(input seq_ctrl_t c);
    @(posedge clk);
    ctrl <= c;
    @(posedge clk);
    ctrl <= '0;
    #1;
  endtask

  // Bounded wait: a hang ends the run as a mismatch
  task automatic wait_drive(input logic runLvl, input logic [1:0] r);
    waited = 0;
    while (!(drive.run === runLvl && (runLvl === 1'b0 || drive.rampSel === r))) begin
      @(posedge clk);
      #1;
      waited++;
      if (waited > 3000) begin
        errors++;
        $display("mismatch at %0t: wait expired", $time);
        complete_run();
      end
    end
  endtask

  task automatic start_look(input seq_ctrl_t c);
    // Seek then run, full step outputs stand two edges after the pulse
    pulse(c);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic chk_span(input int lo, input int hi);
    chk_val(16'(waited >= lo && waited <= hi), 16'h0001, "step duration");
  endtask

  task automatic stop_now;
    pulse(StopP);
    wait_drive(1'b0, 2'h0);
  endtask

  initial begin
    nrst    = 1'b0;
    busReq  = '0;
    ctrl    = '0;
    errors  = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk_val({12'h000, drive.run, drive.reverse, drive.rampSel}, 16'h0000, "drive flags");
    chk_reg(`SEQ_ADDR_END_MODE, 16'(`SEQ_END_MODE_RST));
    chk_reg(`SEQ_ADDR_RETAIN, 16'(`SEQ_RETAIN_RST));
    chk_reg(`SEQ_ADDR_TIME_UNIT, 16'h0000);
    chk_reg(`SEQ_ADDR_OUT_SEL, 16'h0000);
    for (int n = 0; n < 16; n++) begin
      chk_reg({`SEQ_GRP_RUN_TIME, 4'(n)}, `SEQ_RUN_TIME_RST);
      chk_reg({`SEQ_GRP_RAMP, 4'(n)}, 16'h0000);
      chk_reg({`SEQ_GRP_REF, 4'(n)}, `SEQ_REF_RST);
    end
    bus_wr(8'h7F, 16'h1234);
    chk_reg(8'h7F, 16'h0000);
    bus_wr(`SEQ_ADDR_STATUS, 16'hFFFF);
    chk_reg(`SEQ_ADDR_STATUS, 16'h0000);
    bus_wr(8'h1F, 16'hFFFF);
    chk_reg(8'h1F, 16'hFFFF);
    bus_wr(8'h2F, 16'hFFFF);
    chk_reg(8'h2F, 16'h0003);
    bus_wr(8'h1F, 16'h0000);
    $display("test registers done");

    // Step 0 reverse, step 1 empty and skipped, step 2 forward
    bus_wr(8'h10, 16'h0002);
    bus_wr(8'h20, 16'h0001);
    bus_wr(8'h30, 16'hFF9C);
    bus_wr(8'h12, 16'h0005);
    bus_wr(8'h22, 16'h0002);
    bus_wr(8'h32, 16'h0032);
    start_look(RunP);
    chk_val({14'h0000, drive.rampSel}, 16'h0001, "first ramp");
    chk_val({15'h0000, drive.reverse}, 16'h0001, "reverse");
    chk_val(drive.freqRef, 16'h0064, "freq step0");
    wait_drive(1'b1, 2'h2);
    chk_span(TenthCycles, 4 * TenthCycles);
    chk_val({15'h0000, drive.reverse}, 16'h0000, "forward");
    chk_val(drive.freqRef, 16'h0032, "freq step2");
    wait_drive(1'b0, 2'h0);
    repeat (50) @(posedge clk);
    #1;
    chk_val({15'h0000, drive.run}, 16'h0000, "stays halted");
    bus_rd(`SEQ_ADDR_STATUS, got);
    chk_val(got & 16'h0030, 16'h0000, "idle state");
    $display("test stop after cycle done");

    bus_wr(`SEQ_ADDR_TIME_UNIT, 16'h0001);
    pulse(RunP);
    wait_drive(1'b1, 2'h1);
    wait_drive(1'b1, 2'h2);
    chk_span((2 * HourScale - 1) * TenthCycles, (2 * HourScale + 2) * TenthCycles);
    wait_drive(1'b0, 2'h0);
    bus_wr(`SEQ_ADDR_TIME_UNIT, 16'h0000);
    $display("test hour unit done");

    bus_wr(`SEQ_ADDR_END_MODE, 16'h0001);
    pulse(RunP);
    wait_drive(1'b1, 2'h2);
    repeat (120) @(posedge clk);
    #1;
    chk_val({15'h0000, drive.run}, 16'h0001, "keeps running");
    chk_val(drive.freqRef, 16'h0032, "keeps last freq");
    stop_now();
    $display("test keep final done");

    bus_wr(`SEQ_ADDR_END_MODE, 16'h0002);
    pulse(RunP);
    wait_drive(1'b1, 2'h2);
    wait_drive(1'b1, 2'h1);
    chk_val(drive.freqRef, 16'h0064, "restart freq");
    stop_now();
    $display("test repeat done");

    bus_wr(`SEQ_ADDR_END_MODE, 16'h0000);
    bus_wr(`SEQ_ADDR_OUT_SEL, 16'h0001);
    start_look(RunP);
    chk_val(drive.voltRef, 16'h0064, "volt ref");
    chk_val(drive.freqRef, 16'h0000, "freq idle");
    wait_drive(1'b0, 2'h0);
    bus_wr(`SEQ_ADDR_OUT_SEL, 16'h0000);
    $display("test voltage output done");

    // Stop in step 2, then start again with and without stop retention
    bus_wr(`SEQ_ADDR_RETAIN, 16'h0010);
    pulse(RunP);
    wait_drive(1'b1, 2'h2);
    stop_now();
    pulse(StopP);
    start_look(RunP);
    chk_val({14'h0000, drive.rampSel}, 16'h0002, "resume after stop");
    stop_now();
    bus_wr(`SEQ_ADDR_RETAIN, 16'h0000);
    pulse(RunP);
    wait_drive(1'b1, 2'h2);
    stop_now();
    start_look(RunP);
    chk_val({14'h0000, drive.rampSel}, 16'h0001, "restart after stop");
    stop_now();
    $display("test stop retention done");

    bus_wr(`SEQ_ADDR_RETAIN, 16'h0001);
    pulse(RunP);
    wait_drive(1'b1, 2'h2);
    pulse(LossP);
    wait_drive(1'b0, 2'h0);
    start_look(RetP);
    chk_val({15'h0000, drive.run}, 16'h0001, "running after return");
    chk_val({14'h0000, drive.rampSel}, 16'h0002, "resume after loss");
    stop_now();
    bus_wr(`SEQ_ADDR_RETAIN, 16'h0000);
    pulse(RunP);
    wait_drive(1'b1, 2'h2);
    pulse(LossP);
    wait_drive(1'b0, 2'h0);
    start_look(RetP);
    chk_val({14'h0000, drive.rampSel}, 16'h0001, "no resume after loss");
    stop_now();
    $display("test power retention done");
    complete_run();
  end
endmodule
